// ### rtl/xad_core.sv
// execute core for the xor and direction-load instructions
// Function
// - direction-load copies all of W into direction register 5, 6 or 7.
// - literal xor: W xor 8-bit immediate, result back into W.
// - literal xor has top nibble 1111; only zero flag changes.
// - file xor matches 0001 10, then destination bit, then 5-bit address.
// - file xor: W xor file; dest 0 to W, 1 to file; zero updated.
`timescale 1ns/1ns
`default_nettype none
module xad_core
  import xad_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic INSTR_VALID_IN,
  input wire logic [OPC_W-1:0] INSTR_IN,
  input wire logic [DATA_W-1:0] FILE_RD_DATA_IN,
  output logic [DATA_W-1:0] W_OUT,
  output logic ZERO_OUT,
  output logic FILE_WR_EN_OUT,
  output logic [FADDR_W-1:0] FILE_ADDR_OUT,
  output logic [DATA_W-1:0] FILE_WR_DATA_OUT,
  output logic [DATA_W-1:0] DIR5_OUT,
  output logic [DATA_W-1:0] DIR6_OUT,
  output logic [DATA_W-1:0] DIR7_OUT,
  output logic EXEC_DONE_OUT,
  output logic ILLEGAL_OUT
);
  xad_dec_if dif ();

  logic [DATA_W-1:0] w_q;
  logic zero_q;
  logic fwr_q;
  logic [FADDR_W-1:0] faddr_q;
  logic [DATA_W-1:0] fdata_q;
  logic [DATA_W-1:0] dir_q [DIR_NUM];
  logic done_q;
  logic illegal_q;
  logic exec;

  assign dif.instr = INSTR_IN;
  assign dif.w = w_q;
  assign dif.fdata = FILE_RD_DATA_IN;

  xad_decode_unit u_dec (
    .dec(dif)
  );

  // runs only for a valid word that this slice decodes
  assign exec = INSTR_VALID_IN && dif.op != OP_NONE;

  // working register
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      w_q <= W_RESET;
    end else if (exec && (dif.op == OP_XLIT || (dif.op == OP_XFILE && !dif.dest_file))) begin
      w_q <= dif.result;
    end
  end

  // zero flag, touched only by the two xor forms
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      zero_q <= ZERO_RESET;
    end else if (exec && (dif.op == OP_XLIT || dif.op == OP_XFILE)) begin
      zero_q <= dif.zero;
    end
  end

  // file write-back port, one-cycle strobe
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      fwr_q <= 1'b0;
      faddr_q <= FADDR_RESET;
      fdata_q <= W_RESET;
    end else begin
      fwr_q <= exec && dif.op == OP_XFILE && dif.dest_file;
      if (exec && dif.op == OP_XFILE) begin
        faddr_q <= dif.faddr;
        fdata_q <= dif.result;
      end
    end
  end

  // direction registers
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      for (int i = 0; i < DIR_NUM; i++) begin
        dir_q[i] <= DIR_RESET;
      end
    end else if (exec && dif.op == OP_DIR) begin
      dir_q[dif.dir_sel] <= dif.result;
    end
  end

  // completion and unknown-opcode strobes
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      done_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      done_q <= exec;
      illegal_q <= INSTR_VALID_IN && dif.op == OP_NONE;
    end
  end

  // every output straight from its flop
  assign W_OUT = w_q;
  assign ZERO_OUT = zero_q;
  assign FILE_WR_EN_OUT = fwr_q;
  assign FILE_ADDR_OUT = faddr_q;
  assign FILE_WR_DATA_OUT = fdata_q;
  assign DIR5_OUT = dir_q[0];
  assign DIR6_OUT = dir_q[1];
  assign DIR7_OUT = dir_q[2];
  assign EXEC_DONE_OUT = done_q;
  assign ILLEGAL_OUT = illegal_q;

  // assertion helpers, decoded apart from the shared function on purpose
  logic [DATA_W-1:0] lit;
  logic [FADDR_W-1:0] fsel;
  logic to_file;
  logic is_xlit;
  logic is_xfile;
  logic is_dir;
  logic is_known;
  assign lit = INSTR_IN[DATA_W-1:0];
  assign fsel = INSTR_IN[FADDR_W-1:0];
  assign to_file = INSTR_IN[DEST_BIT];
  assign is_xlit = INSTR_VALID_IN && INSTR_IN[11:8] == XOR_LIT_TOP;
  assign is_xfile = INSTR_VALID_IN && INSTR_IN[11:6] == XOR_FILE_TOP;
  assign is_dir = INSTR_VALID_IN && INSTR_IN[11:3] == DIR_LOAD_TOP
                  && INSTR_IN[2:0] >= DIR_FIRST && INSTR_IN[2:0] <= DIR_LAST;
  assign is_known = is_xlit || is_xfile || is_dir;

  // direction registers
  a_dir_load_copy: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    is_dir && INSTR_IN[2:0] == DIR_FIRST |=> DIR5_OUT == $past(w_q)
      && W_OUT == $past(w_q) && $stable(DIR6_OUT) && $stable(DIR7_OUT))
    else $error("direction load to port 5 wrong");

  a_dir6_load: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    is_dir && INSTR_IN[2:0] == DIR_FIRST + 3'h1 |=> DIR6_OUT == $past(w_q)
      && $stable(DIR5_OUT) && $stable(DIR7_OUT))
    else $error("direction load to port 6 wrong");

  a_dir7_load: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    is_dir && INSTR_IN[2:0] == DIR_LAST |=> DIR7_OUT == $past(w_q)
      && $stable(DIR5_OUT) && $stable(DIR6_OUT))
    else $error("direction load to port 7 wrong");

  a_dir_hold: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    !is_dir |=> $stable(DIR5_OUT)
      && $stable(DIR6_OUT) && $stable(DIR7_OUT))
    else $error("direction register changed without a load");

  a_dir_refused: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    INSTR_VALID_IN && INSTR_IN[11:3] == DIR_LOAD_TOP && !is_dir
      |=> ILLEGAL_OUT && !EXEC_DONE_OUT && $stable(W_OUT))
    else $error("direction load outside ports 5 to 7 accepted");

  // literal xor
  a_xor_lit_w: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    is_xlit |=> W_OUT == ($past(w_q) ^ $past(lit)))
    else $error("literal xor result wrong");

  a_xor_lit_zero: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    is_xlit |=> ZERO_OUT == (W_OUT == '0) && !FILE_WR_EN_OUT)
    else $error("literal xor zero flag wrong");

  a_xor_lit_self: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    is_xlit && lit == w_q |=> ZERO_OUT && W_OUT == '0)
    else $error("literal xor of W with itself did not set zero");

  a_xor_lit_only: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    is_xlit |=> $stable(FILE_ADDR_OUT)
      && $stable(FILE_WR_DATA_OUT) && $stable(DIR5_OUT))
    else $error("literal xor touched more than W and zero");

  a_zero_keep: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    !(is_xlit || is_xfile) |=> $stable(ZERO_OUT))
    else $error("zero flag changed outside the xor forms");

  // file xor
  a_xor_file_addr: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    is_xfile |=> FILE_ADDR_OUT == $past(fsel)
      && FILE_WR_EN_OUT == $past(to_file))
    else $error("file xor address or destination wrong");

  a_file_regs_hold: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    !is_xfile |=> $stable(FILE_ADDR_OUT) && $stable(FILE_WR_DATA_OUT))
    else $error("file address or data changed without a file xor");

  a_xor_file_dest: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    is_xfile && to_file |=> FILE_WR_DATA_OUT == ($past(w_q) ^ $past(FILE_RD_DATA_IN))
      && W_OUT == $past(w_q) && ZERO_OUT == (FILE_WR_DATA_OUT == '0))
    else $error("file xor to file wrong");

  a_xor_file_w: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    is_xfile && !to_file |=> W_OUT == ($past(w_q) ^ $past(FILE_RD_DATA_IN))
      && !FILE_WR_EN_OUT && ZERO_OUT == (W_OUT == '0))
    else $error("file xor to W wrong");

  a_w_keep: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    !(is_xlit || (is_xfile && !to_file)) |=> $stable(W_OUT))
    else $error("W changed without an xor to W");

  a_wr_pulse: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    !(is_xfile && to_file) |=> !FILE_WR_EN_OUT)
    else $error("file write strobe without a file xor to file");

  // completion and refusal strobes
  a_single_cycle: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (is_xlit || is_xfile || is_dir) |=> EXEC_DONE_OUT && !ILLEGAL_OUT)
    else $error("instruction not done in one cycle");

  a_illegal_word: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    INSTR_VALID_IN && !is_known |=> ILLEGAL_OUT && !EXEC_DONE_OUT
      && !FILE_WR_EN_OUT)
    else $error("unknown word not flagged");

  a_idle_quiet: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    !INSTR_VALID_IN |=> !EXEC_DONE_OUT && !ILLEGAL_OUT && !FILE_WR_EN_OUT
      && $stable(W_OUT) && $stable(ZERO_OUT))
    else $error("state changed with no valid word");
endmodule
`default_nettype wire

// ### rtl/xad_pkg.sv
// constants, op codes and decode helper for the xor / direction-load slice
package xad_pkg;
  localparam int unsigned OPC_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADDR_W = 5;
  localparam int unsigned DIR_NUM = 3;
  localparam logic [3:0] XOR_LIT_TOP = 4'hf;
  localparam logic [5:0] XOR_FILE_TOP = 6'h06;
  localparam logic [8:0] DIR_LOAD_TOP = 9'h000;
  localparam logic [2:0] DIR_FIRST = 3'h5;
  localparam logic [2:0] DIR_LAST = 3'h7;
  localparam int unsigned DEST_BIT = 5;
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DIR_RESET = 8'hff;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic [FADDR_W-1:0] FADDR_RESET = 5'h00;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_DIR = 2'b01,
    OP_XLIT = 2'b10,
    OP_XFILE = 2'b11
  } xad_op_t;

  function automatic xad_op_t xad_decode(input logic [OPC_W-1:0] instr);
    xad_op_t op;
    op = OP_NONE;
    if (instr[11:8] == XOR_LIT_TOP) begin
      op = OP_XLIT;
    end else if (instr[11:6] == XOR_FILE_TOP) begin
      op = OP_XFILE;
    end else if (instr[11:3] == DIR_LOAD_TOP && instr[2:0] >= DIR_FIRST
                 && instr[2:0] <= DIR_LAST) begin
      op = OP_DIR;
    end
    return op;
  endfunction
endpackage

// ### rtl/xad_dec_if.sv
// carrier between the core and its decode/xor unit
`timescale 1ns/1ns
`default_nettype none
interface xad_dec_if;
  import xad_pkg::*;
  logic [OPC_W-1:0] instr;
  logic [DATA_W-1:0] w;
  logic [DATA_W-1:0] fdata;
  xad_op_t op;
  logic [DATA_W-1:0] result;
  logic zero;
  logic dest_file;
  logic [FADDR_W-1:0] faddr;
  logic [1:0] dir_sel;
  modport dec (input instr, w, fdata, output op, result, zero, dest_file, faddr, dir_sel);
  modport core (output instr, w, fdata, input op, result, zero, dest_file, faddr, dir_sel);
endinterface
`default_nettype wire

// ### rtl/xad_decode_unit.sv
// combinational decode and xor datapath
`timescale 1ns/1ns
`default_nettype none
module xad_decode_unit
  import xad_pkg::*;
(
  xad_dec_if.dec dec
);
  always_comb begin
    dec.op = xad_decode(dec.instr);
    dec.result = dec.w;
    dec.dest_file = 1'b0;
    dec.faddr = dec.instr[FADDR_W-1:0];
    dec.dir_sel = 2'(dec.instr[2:0] - DIR_FIRST);
    case (dec.op)
      OP_XLIT: begin
        dec.result = dec.w ^ dec.instr[DATA_W-1:0];
      end
      OP_XFILE: begin
        dec.result = dec.w ^ dec.fdata;
        dec.dest_file = dec.instr[DEST_BIT];
      end
      OP_DIR: begin
        dec.result = dec.w;
      end
      default: begin
        dec.result = dec.w;
      end
    endcase
    dec.zero = (dec.result == '0);
  end
endmodule
`default_nettype wire

// ### tb/xad_core_test.sv
// self-checking bench for the xor and direction-load core
`timescale 1ns/1ns
`default_nettype none
module xad_core_test;
  import xad_pkg::*;
  logic clk, rst_n, vld, z_o, fwe, done, ill, z_m, we_m, dn_m, il_m;
  logic [OPC_W-1:0] ins;
  logic [DATA_W-1:0] frd, w_o, fwd, d5, d6, d7, w_m, fd_m, r;
  logic [DATA_W-1:0] dir_m [5:7];
  logic [FADDR_W-1:0] fa, fa_m;
  int fails, checked, n;
  localparam int RUN_CYCLES = 540;
  xad_core uut (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .INSTR_VALID_IN(vld), .INSTR_IN(ins),
    .FILE_RD_DATA_IN(frd), .W_OUT(w_o), .ZERO_OUT(z_o), .FILE_WR_EN_OUT(fwe),
    .FILE_ADDR_OUT(fa), .FILE_WR_DATA_OUT(fwd), .DIR5_OUT(d5), .DIR6_OUT(d6),
    .DIR7_OUT(d7), .EXEC_DONE_OUT(done), .ILLEGAL_OUT(ill));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // reference model of one instruction
  function automatic void predict();
    we_m = 1'b0;
    dn_m = 1'b0;
    il_m = 1'b0;
    if (vld) begin
      if (ins[11:8] == 4'hf) begin
        w_m = w_m ^ ins[7:0];
        z_m = (w_m == 8'h00);
        dn_m = 1'b1;
      end else if (ins[11:6] == 6'h06) begin
        r = w_m ^ frd;
        z_m = (r == 8'h00);
        dn_m = 1'b1;
        fa_m = ins[4:0];
        fd_m = r;
        if (ins[5]) we_m = 1'b1;
        else w_m = r;
      end else if (ins[11:3] == 9'h000 && ins[2:0] >= 3'h5) begin
        dir_m[ins[2:0]] = w_m;
        dn_m = 1'b1;
      end else il_m = 1'b1;
    end
  endfunction
  task automatic run(input logic v, input logic [11:0] i, input logic [7:0] f);
    vld = v;
    ins = i;
    frd = f;
    predict();
    @(posedge clk);
    #1;
    chk(w_o, w_m);
    chk({7'h00, z_o}, {7'h00, z_m});
    chk(d5, dir_m[5]);
    chk(d6, dir_m[6]);
    chk(d7, dir_m[7]);
    chk({6'h00, fwe, done}, {6'h00, we_m, dn_m});
    chk({7'h00, ill}, {7'h00, il_m});
    chk({3'h0, fa}, {3'h0, fa_m});
    chk(fwd, fd_m);
  endtask
  // reset held for a number of edges, model takes the reset values
  task automatic reset_dut(input int cycles);
    rst_n = 1'b0;
    vld = 1'b0;
    w_m = W_RESET;
    z_m = ZERO_RESET;
    dir_m = '{DIR_RESET, DIR_RESET, DIR_RESET};
    fa_m = FADDR_RESET;
    fd_m = W_RESET;
    repeat (cycles) @(posedge clk);
    #1;
    rst_n = 1'b1;
  endtask
  function automatic logic [11:0] pick(input logic [7:0] w);
    logic [11:0] i;
    i = 12'($urandom);
    case ($urandom_range(0, 4))
      0: i[11:8] = 4'hf;
      1: i[11:6] = 6'h06;
      2: i = {9'h000, 3'($urandom_range(5, 7))};
      3: i = {4'hf, w};
      default: ;
    endcase
    return i;
  endfunction
  initial begin
    repeat (4 * RUN_CYCLES) @(posedge clk);
    fails++;
    $display("FAIL %0t watchdog expired", $time);
    complete_run();
  end
  initial begin
    fails = 0;
    checked = 0;
    ins = 12'h000;
    frd = 8'h00;
    n = $urandom(32'h57a0);
    reset_dut(10);
    run(1'b0, 12'hfff, 8'h00);
    $display("test reset done");
    run(1'b1, 12'hfb5, 8'h00);
    run(1'b1, 12'hfaf, 8'h00);
    run(1'b1, 12'hfaf, 8'h00);
    run(1'b1, 12'h1a3, 8'haf);
    run(1'b1, 12'h1bf, 8'h00);
    run(1'b1, 12'h005, 8'h00);
    run(1'b1, 12'h006, 8'h00);
    run(1'b1, 12'h007, 8'h00);
    run(1'b1, 12'h004, 8'h00);
    run(1'b1, 12'h008, 8'h00);
    run(1'b1, 12'h19f, 8'hb5);
    run(1'b1, 12'hf00, 8'h00);
    run(1'b0, 12'hfff, 8'h00);
    run(1'b1, 12'h1e0, 8'h00);
    $display("test corners done");
    repeat (500) run(1'($urandom_range(0, 7) != 0), pick(w_m), 8'($urandom));
    $display("test random done");
    reset_dut(3);
    run(1'b0, 12'hfff, 8'h00);
    run(1'b1, 12'h005, 8'h00);
    run(1'b1, 12'hf5a, 8'h00);
    run(1'b1, 12'h189, 8'h5a);
    run(1'b1, 12'h007, 8'h00);
    run(1'b1, 12'h009, 8'h00);
    $display("test mid reset done");
    complete_run();
  end
endmodule
`default_nettype wire
